// ---- bridge_map.vh ----
`ifndef BRIDGE_MAP_VH
`define BRIDGE_MAP_VH
// ==========================================
// Timing
`define CLK_PERIOD_NS   4
`define T_SU_DAT_NS     100
`define SU_CYC          ((`T_SU_DAT_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// ==========================================
// Strap decode: ratio in thousandths of the supply
`define RATIO_ZERO      10'h000
`define RATIO1_MIN      10'h072
`define RATIO1_MAX      10'h0BA
`define RATIO2_MIN      10'h129
`define RATIO2_MAX      10'h15B
`define RATIO3_MIN      10'h2E6
`define RATIO3_MAX      10'h3E8
`define STRAP_ADDR0     7'h58
`define STRAP_ADDR1     7'h59
`define STRAP_ADDR2     7'h5A
`define STRAP_ADDR3     7'h5D
// ==========================================
// Alias table
`define ALIAS_SENSOR_N  4'h8
`define ALIAS_DISPLAY_N 4'h1
`endif

// ---- i2c_bridge_addressing.v ----
`timescale 1ns/1ns
`include "bridge_map.vh"
// Overview of operation
// - With pass-through on, a host transaction for a remote address is forwarded over the link.
// - With pass-through off, host transactions for remote addresses are not forwarded.
// - While bridging, SCL is held low on the ninth clock of each address or write byte, before acknowledge, and before the first clock of each read byte.
// - SCL is never driven otherwise, and is released once the remote response is back.
// - Strap ratio 0 selects address 0x58 and ratio 0.114 to 0.186 selects 0x59.
// - Strap ratio 0.297 to 0.347 selects 0x5A and 0.742 to 1.0 selects 0x5D.
// - In sensor mode up to eight aliases are remapped to their target addresses.
// - In display mode exactly one alias-to-target mapping is used.
// - A transaction to a programmed alias is issued remotely with the mapped target address.
// - The far end replays each forwarded request as bus master to its local peripherals.
// - The host-facing interface acts as a slave accepting the host's transactions.
// - The slave interface works at up to 400 kbps with fast-mode timing.
// - The own address comes from the strap unless the address source select overrides it.
module i2c_bridge_addressing (
  // Clock and reset
  input  wire        sys_clk,
  input  wire        rst_n,
  input  wire        ce,
  // Host-facing bus pins
  input  wire        scl_in,
  output reg         scl_out,
  output reg         scl_oe,
  input  wire        sda_in,
  output reg         sda_out,
  output reg         sda_oe,
  // Address configuration
  input  wire [9:0]  address_strap_pin,
  input  wire        address_source_select,
  input  wire [6:0]  reg_slave_address,
  output reg  [6:0]  own_address,
  // Bridging configuration
  input  wire        pass_through_en,
  input  wire        sensor_mode,
  input  wire [55:0] alias_ids,
  input  wire [55:0] target_slave_address,
  // Link requests
  output reg         fwd_valid,
  output reg         fwd_first,
  output reg         fwd_read,
  output reg  [7:0]  fwd_byte,
  output reg         fwd_stop,
  // Link responses
  input  wire        rsp_valid,
  input  wire        rsp_ack,
  input  wire [7:0]  rsp_data
);

  localparam [7:0] S_IDLE  = 8'h01;
  localparam [7:0] S_ADDR  = 8'h02;
  localparam [7:0] S_WR    = 8'h04;
  localparam [7:0] S_HOLD  = 8'h08;
  localparam [7:0] S_SETUP = 8'h10;
  localparam [7:0] S_ACK   = 8'h20;
  localparam [7:0] S_RD    = 8'h40;
  localparam [7:0] S_RACK  = 8'h80;
  localparam integer SU_LAST = `SU_CYC - 1;
  // ==========================================
  // Helpers
  function [6:0] decode_strap;
    input [9:0] r;
    begin
      if (r >= `RATIO3_MIN && r <= `RATIO3_MAX)
        decode_strap = `STRAP_ADDR3;
      else if (r >= `RATIO2_MIN && r <= `RATIO2_MAX)
        decode_strap = `STRAP_ADDR2;
      else if (r >= `RATIO1_MIN && r <= `RATIO1_MAX)
        decode_strap = `STRAP_ADDR1;
      else
        decode_strap = `STRAP_ADDR0;
    end
  endfunction
  // Returns {hit, mapped address}; lowest matching entry wins
  function [7:0] map_alias;
    input [6:0]  a;
    input        sensor;
    input [55:0] al;
    input [55:0] tg;
    integer      i;
    reg   [3:0]  n;
    begin
      map_alias = {1'b0, a};
      n = sensor ? `ALIAS_SENSOR_N : `ALIAS_DISPLAY_N;
      for (i = 7; i >= 0; i = i - 1) begin
        if (i < n && al[i*7 +: 7] == a)
          map_alias = {1'b1, tg[i*7 +: 7]};
      end
    end
  endfunction
  // ==========================================
  // Pin synchronisers
  reg  [1:0] scl_sy_r;
  reg  [1:0] sda_sy_r;
  reg        scl_d_r;
  reg        sda_d_r;
  reg  [9:0] strap_s1_r;
  reg  [9:0] strap_s2_r;
  wire       scl_s  = scl_sy_r[1];
  wire       sda_s  = sda_sy_r[1];
  wire       scl_rise = scl_s & ~scl_d_r;
  wire       scl_fall = ~scl_s & scl_d_r;
  wire       start_c = scl_s & scl_d_r & sda_d_r & ~sda_s;
  wire       stop_c  = scl_s & scl_d_r & ~sda_d_r & sda_s;

  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_sy_r   <= 2'h3;
      sda_sy_r   <= 2'h3;
      scl_d_r    <= 1'b1;
      sda_d_r    <= 1'b1;
      strap_s1_r <= 10'h000;
      strap_s2_r <= 10'h000;
    end else if (ce) begin
      scl_sy_r   <= {scl_sy_r[0], scl_in};
      sda_sy_r   <= {sda_sy_r[0], sda_in};
      scl_d_r    <= scl_s;
      sda_d_r    <= sda_s;
      strap_s1_r <= address_strap_pin;
      strap_s2_r <= strap_s1_r;
    end
  end

  // ==========================================
  // Own address
  // Strap is caught once, after the synchroniser has filled
  reg  [1:0] strap_cnt_r;
  reg  [6:0] strap_addr_r;

  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      strap_cnt_r  <= 2'h0;
      strap_addr_r <= `STRAP_ADDR0;
      own_address  <= `STRAP_ADDR0;
    end else if (ce) begin
      if (strap_cnt_r != 2'h3)
        strap_cnt_r <= strap_cnt_r + 2'h1;
      if (strap_cnt_r == 2'h2)
        strap_addr_r <= decode_strap(strap_s2_r);
      own_address <= address_source_select ? reg_slave_address : strap_addr_r;
    end
  end

  // ==========================================
  // Slave engine
  reg  [7:0] state_r;
  reg  [3:0] bitcnt_r;
  reg  [7:0] shift_r;
  reg  [7:0] rd_data_r;
  reg  [4:0] su_cnt_r;
  reg        rw_r;
  reg        ack_r;
  reg        local_r;
  reg        fwd_act_r;
  reg        rd_next_r;
  reg        host_ack_r;
  wire [7:0] mapped = map_alias(shift_r[7:1], sensor_mode, alias_ids, target_slave_address);

  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r    <= S_IDLE;
      bitcnt_r   <= 4'h0;
      shift_r    <= 8'h00;
      rd_data_r  <= 8'h00;
      su_cnt_r   <= 5'h00;
      rw_r       <= 1'b0;
      ack_r      <= 1'b0;
      local_r    <= 1'b0;
      fwd_act_r  <= 1'b0;
      rd_next_r  <= 1'b0;
      host_ack_r <= 1'b0;
      scl_out    <= 1'b0;
      scl_oe     <= 1'b0;
      sda_out    <= 1'b0;
      sda_oe     <= 1'b0;
      fwd_valid  <= 1'b0;
      fwd_first  <= 1'b0;
      fwd_read   <= 1'b0;
      fwd_byte   <= 8'h00;
      fwd_stop   <= 1'b0;
    end else if (ce) begin
      fwd_valid <= 1'b0;
      fwd_stop  <= 1'b0;
      if (start_c) begin
        // Repeated start is carried to the far end by fwd_first on the next address
        state_r  <= S_ADDR;
        bitcnt_r <= 4'h0;
        sda_oe   <= 1'b0;
        scl_oe   <= 1'b0;
        local_r  <= 1'b0;
      end else if (stop_c) begin
        if (fwd_act_r)
          fwd_stop <= 1'b1;
        fwd_act_r <= 1'b0;
        local_r   <= 1'b0;
        state_r   <= S_IDLE;
        sda_oe    <= 1'b0;
        scl_oe    <= 1'b0;
      end else begin
        case (state_r)
          S_ADDR, S_WR: begin
            if (scl_rise) begin
              shift_r  <= {shift_r[6:0], sda_s};
              bitcnt_r <= bitcnt_r + 4'h1;
            end else if (scl_fall && bitcnt_r == 4'h8) begin
              if (state_r == S_ADDR)
                rw_r <= shift_r[0];
              if (state_r == S_ADDR && shift_r[7:1] == own_address) begin
                local_r <= 1'b1;
                ack_r   <= 1'b1;
                sda_oe  <= 1'b1;
                state_r <= S_ACK;
              end else if (state_r == S_WR && local_r) begin
                ack_r   <= 1'b1;
                sda_oe  <= 1'b1;
                state_r <= S_ACK;
              end else if ((state_r == S_ADDR && pass_through_en) || (state_r == S_WR && fwd_act_r)) begin
                // Stretch starts at the low phase of the ninth clock
                scl_oe    <= 1'b1;
                fwd_valid <= 1'b1;
                fwd_first <= (state_r == S_ADDR);
                fwd_read  <= 1'b0;
                fwd_byte  <= (state_r == S_ADDR) ? {mapped[6:0], shift_r[0]} : shift_r;
                fwd_act_r <= 1'b1;
                rd_next_r <= 1'b0;
                state_r   <= S_HOLD;
              end else begin
                state_r <= S_IDLE;
              end
            end
          end
          S_HOLD: begin
            if (rsp_valid) begin
              ack_r     <= rsp_ack;
              rd_data_r <= rsp_data;
              sda_oe    <= rd_next_r ? ~rsp_data[7] : rsp_ack;
              su_cnt_r  <= 5'h00;
              state_r   <= S_SETUP;
            end
          end
          S_SETUP: begin
            // SDA settles a fast-mode setup time before SCL is let go
            su_cnt_r <= su_cnt_r + 5'h01;
            if (su_cnt_r == SU_LAST[4:0]) begin
              scl_oe   <= 1'b0;
              bitcnt_r <= 4'h0;
              state_r  <= rd_next_r ? S_RD : S_ACK;
            end
          end
          S_ACK, S_RACK: begin
            if (state_r == S_RACK && scl_rise) begin
              host_ack_r <= ~sda_s;
            end else if (scl_fall) begin
              sda_oe   <= 1'b0;
              bitcnt_r <= 4'h0;
              if (state_r == S_ACK ? !ack_r : !host_ack_r) begin
                state_r <= S_IDLE;
              end else if (rw_r && fwd_act_r) begin
                scl_oe    <= 1'b1;
                fwd_valid <= 1'b1;
                fwd_first <= 1'b0;
                fwd_read  <= 1'b1;
                fwd_byte  <= 8'h00;
                rd_next_r <= 1'b1;
                state_r   <= S_HOLD;
              end else if (rw_r) begin
                // No local registers: local reads return zero
                rd_data_r <= 8'h00;
                sda_oe    <= 1'b1;
                state_r   <= S_RD;
              end else begin
                state_r <= S_WR;
              end
            end
          end
          S_RD: begin
            if (scl_fall) begin
              bitcnt_r  <= bitcnt_r + 4'h1;
              rd_data_r <= {rd_data_r[6:0], 1'b0};
              if (bitcnt_r == 4'h7) begin
                sda_oe  <= 1'b0;
                state_r <= S_RACK;
              end else begin
                sda_oe <= ~rd_data_r[6];
              end
            end
          end
          default: begin
            state_r <= S_IDLE;
          end
        endcase
      end
    end
  end
endmodule // i2c_bridge_addressing

// ---- bridge_sva.sv ----
`timescale 1ns/1ns
// ==========
// Port checker
module bridge_sva (
  // Clock and reset
  input wire       sys_clk,
  input wire       rst_n,
  // Bus pins
  input wire       scl_out,
  input wire       scl_oe,
  input wire       sda_oe,
  input wire       sda_out,
  // Link side
  input wire       pass_through_en,
  input wire       fwd_valid,
  input wire       fwd_first,
  input wire       fwd_read,
  input wire       fwd_stop,
  input wire       rsp_valid,
  input wire       rsp_ack,
  input wire [7:0] rsp_data
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // Kind of the last request; a read answer drives data, not an ack
  reg rd_r;
  always @(posedge sys_clk) begin
    if (fwd_valid)
      rd_r <= fwd_read;
  end
  scl_zero_a: assert property (scl_out == 1'b0)
    else $error("clock driven high");
  sda_zero_a: assert property (sda_out == 1'b0)
    else $error("data driven high");
  fwd_pulse_a: assert property (fwd_valid |=> !fwd_valid)
    else $error("request not a pulse");
  stop_pulse_a: assert property (fwd_stop |=> !fwd_stop)
    else $error("stop not a pulse");
  fwd_gate_a: assert property (fwd_valid && fwd_first |-> pass_through_en)
    else $error("forward while disabled");
  fwd_stretch_a: assert property (fwd_valid |-> ##[0:3] scl_oe)
    else $error("no stretch");
  stretch_release_a: assert property (rsp_valid |-> ##[1:40] !scl_oe)
    else $error("stretch held");
  ack_relay_a: assert property (rsp_valid && rsp_ack && !rd_r |=> sda_oe)
    else $error("ack lost");
  read_zero_a: assert property (rsp_valid && rd_r && !rsp_data[7] |=> sda_oe)
    else $error("read bit lost");
  cover property (fwd_valid && fwd_read);
  cover property (rsp_valid && !rsp_ack);
  cover property (fwd_stop);
endmodule // bridge_sva
bind i2c_bridge_addressing bridge_sva bridge_sva_i (.sys_clk, .rst_n, .scl_out, .scl_oe,
  .sda_oe, .sda_out, .pass_through_en, .fwd_valid, .fwd_first, .fwd_read, .fwd_stop, .rsp_valid,
  .rsp_ack, .rsp_data);

// ---- host_master.sv ----
`timescale 1ns/1ns
// ==========
// Host bus master, open-drain: a drive of 1 pulls the line low
module host_master (
  // Line levels
  input wire scl_line,
  input wire sda_line,
  // Pull-low drives
  output reg scl_drv = 1'b0,
  output reg sda_drv = 1'b0
);
  task start_cond;
    begin
      sda_drv = 1'b1;
      #40 scl_drv = 1'b1;
    end
  endtask
  task stop_cond;
    begin
      #20 sda_drv = 1'b1;
      #60 scl_drv = 1'b0;
      #40 sda_drv = 1'b0;
      #80;
    end
  endtask
  // Bounded wait so a clock stuck low cannot hang the run
  task automatic bit_io(input b, output s);
    integer n;
    begin
      #20 sda_drv = ~b;
      #60 scl_drv = 1'b0;
      n = 0;
      while (scl_line !== 1'b1 && n < 500) begin
        #4 n = n + 1;
      end
      #40 s = sda_line;
      #40 scl_drv = 1'b1;
    end
  endtask
  // MSB first; ninth bit released for the slave ack, or as nack on reads
  task automatic xfer(input [7:0] b, output [7:0] d, output ack);
    integer i;
    reg s;
    begin
      for (i = 7; i >= 0; i = i - 1) begin
        bit_io(b[i], s);
        d[i] = s;
      end
      bit_io(1'b1, s);
      ack = ~s;
    end
  endtask
endmodule // host_master

// ---- testbench.sv ----
`timescale 1ns/1ns
`define CHK(g, e) begin comparisons = comparisons + 1; if ((g) !== (e)) begin \
  num_errors = num_errors + 1; $display("mismatch %0t got %h want %h", $time, g, e); end end
module testbench;
  // ==========
  // Stimulus and bus lines; both lines have pull-ups
  reg         sys_clk = 1'b0, rst_n = 1'b0, address_source_select = 1'b0;
  reg         pass_through_en = 1'b1, sensor_mode = 1'b1, rsp_valid = 1'b0, rsp_ack = 1'b0;
  reg  [9:0]  address_strap_pin = 10'h000, got;
  reg  [6:0]  reg_slave_address = 7'h00, ra;
  reg  [55:0] alias_ids = 56'h0, target_slave_address = 56'h0;
  reg  [7:0]  rsp_data = 8'h00, last_rsp = 8'h00;
  reg  [31:0] seed = 32'hC723A7B8;
  reg  [9:0]  log_q [$];
  integer     num_errors = 0, comparisons = 0, cyc = 0, stops = 0, nack_mode = 0, i;
  wire        scl_out, scl_oe, sda_out, sda_oe, host_scl, host_sda;
  wire        fwd_valid, fwd_first, fwd_read, fwd_stop;
  wire [7:0]  fwd_byte;
  wire [6:0]  own_address;
  wire        scl_line = ~((scl_oe & ~scl_out) | host_scl);
  wire        sda_line = ~((sda_oe & ~sda_out) | host_sda);
  always #2 sys_clk = ~sys_clk;
  i2c_bridge_addressing i2c_bridge_addressing_i (.sys_clk, .rst_n, .ce(1'b1), .scl_in(scl_line),
    .scl_out, .scl_oe, .sda_in(sda_line), .sda_out, .sda_oe, .address_strap_pin,
    .address_source_select, .reg_slave_address, .own_address, .pass_through_en, .sensor_mode,
    .alias_ids, .target_slave_address, .fwd_valid, .fwd_first, .fwd_read, .fwd_byte,
    .fwd_stop, .rsp_valid, .rsp_ack, .rsp_data);
  host_master host_master_i (.scl_line, .sda_line, .scl_drv(host_scl), .sda_drv(host_sda));
  // ==========
  // Expectations
  function automatic [31:0] lfsr(input [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // Scanned downward so the lowest matching entry wins
  function automatic [6:0] map_addr(input [6:0] a);
    integer k;
    begin
      map_addr = a;
      for (k = 7; k >= 0; k = k - 1)
        if ((sensor_mode || k == 0) && alias_ids[7*k +: 7] == a)
          map_addr = target_slave_address[7*k +: 7];
    end
  endfunction
  // ==========
  // Link far end, answering after 2 to 65 cycles
  always @(negedge sys_clk) begin
    cyc = cyc + 1;
    if (fwd_stop === 1'b1) stops = stops + 1;
    if (cyc == 60000) begin
      num_errors = num_errors + 1;
      complete_run;
    end
  end
  always begin
    @(negedge sys_clk);
    if (fwd_valid === 1'b1) begin
      log_q.push_back({fwd_first, fwd_read, fwd_byte});
      seed = lfsr(seed);
      repeat (seed[5:0] + 2) @(posedge sys_clk);
      #1 rsp_valid = 1'b1;
      rsp_ack = (nack_mode == 0);
      rsp_data = seed[15:8];
      last_rsp = seed[15:8];
      @(posedge sys_clk);
      #1 rsp_valid = 1'b0;
      rsp_data = ~rsp_data;
    end
  end
  // ==========
  // Sequences
  task automatic trans(input [6:0] a, input rd, input [7:0] wd, input fwd, input ea);
    reg [7:0] d;
    reg       ack;
    integer   s0;
    begin
      s0 = stops;
      host_master_i.start_cond;
      host_master_i.xfer({a, rd}, d, ack);
      `CHK(ack, ea)
      got = log_q.size() ? log_q.pop_front() : 10'h3FF;
      if (fwd) `CHK(got, {2'b10, map_addr(a), rd})
      if (ea) begin
        host_master_i.xfer(rd ? 8'hFF : wd, d, ack);
        got = log_q.size() ? log_q.pop_front() : 10'h3FF;
        if (fwd) `CHK(got, {1'b0, rd, rd ? 8'h00 : wd})
        `CHK(rd ? d : {7'h00, ack}, rd ? (fwd ? last_rsp : 8'h00) : 8'h01)
      end
      host_master_i.stop_cond;
      if (fwd && ea) `CHK(stops, s0 + 1)
      `CHK(log_q.size(), 0)
    end
  endtask
  task automatic strap(input [9:0] lo, input [9:0] hi, input [6:0] ea);
    begin
      seed = lfsr(seed);
      address_strap_pin = lo + seed[9:0] % (hi - lo + 10'h001);
      rst_n = 1'b0;
      repeat (4) @(posedge sys_clk);
      #1 rst_n = 1'b1;
      repeat (8) @(posedge sys_clk);
      #1 `CHK(own_address, ea)
    end
  endtask
  task complete_run;
    begin
      if (num_errors == 0 && comparisons > 0)
        $display("TB: PASS");
      else
        $display("TB: FAIL");
      $finish;
    end
  endtask
  initial begin
    for (i = 0; i < 8; i = i + 1) begin
      alias_ids[7*i +: 7] = 7'(8'h40 + 2 * i);
      target_slave_address[7*i +: 7] = 7'(8'h10 + i);
    end
    strap(10'h000, 10'h000, 7'h58);
    strap(10'h072, 10'h0BA, 7'h59);
    strap(10'h129, 10'h15B, 7'h5A);
    strap(10'h2E6, 10'h3E8, 7'h5D);
    strap(10'h0C8, 10'h118, 7'h58);
    address_source_select = 1'b1;
    reg_slave_address = 7'h33;
    repeat (2) @(posedge sys_clk);
    #1 `CHK(own_address, 7'h33)
    address_source_select = 1'b0;
    for (i = 0; i < 8; i = i + 1) begin
      seed = lfsr(seed);
      trans(alias_ids[7*i +: 7], i[0], seed[7:0], 1'b1, 1'b1);
    end
    sensor_mode = 1'b0;
    trans(7'h40, 1'b0, 8'hA5, 1'b1, 1'b1);
    trans(7'h46, 1'b1, 8'h00, 1'b1, 1'b1);
    trans(7'h58, 1'b0, 8'h3C, 1'b0, 1'b1);
    trans(7'h58, 1'b1, 8'h00, 1'b0, 1'b1);
    pass_through_en = 1'b0;
    trans(7'h42, 1'b0, 8'h5A, 1'b0, 1'b0);
    pass_through_en = 1'b1;
    nack_mode = 1;
    trans(7'h6E, 1'b0, 8'h00, 1'b1, 1'b0);
    nack_mode = 0;
    for (i = 0; i < 8; i = i + 1) begin
      seed = lfsr(seed);
      sensor_mode = seed[0];
      ra = {1'b1, seed[13:8]} ^ {6'h00, seed[13:8] == 6'h18};
      trans(ra, seed[1], seed[23:16], 1'b1, 1'b1);
    end
    complete_run;
  end
endmodule // testbench
